// *** rtl/kmsc_defs.svh ***
// Constants of the key matrix scan controller: offsets, fields, resets, timing.
`ifndef KMSC_DEFS_SVH
`define KMSC_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define KMSC_OFF_SETTING  12'h000
`define KMSC_OFF_OPERAND  12'h004
`define KMSC_OFF_STATUS   12'h008
`define KMSC_OFF_MASK     12'h00C
`define KMSC_OFF_CTRL     12'h010

// ****************************************
// Setting fields
// ****************************************
`define KMSC_BIT_MODE_HI  7
`define KMSC_BIT_PERIODIC 6
`define KMSC_BIT_MODE_MID 5
`define KMSC_BIT_MODE_LO  4

// ****************************************
// Status bits
// ****************************************
`define KMSC_ST_WAKE      0
`define KMSC_ST_CYCLE     1
`define KMSC_ST_KEY       2

// ****************************************
// Reset values
// ****************************************
`define KMSC_RST_SETTING  8'h20
`define KMSC_RST_CTRL     8'h00

// ****************************************
// Timing
// ****************************************
`define KMSC_CLK_NS       5
`define KMSC_FRAME_NS     2000
`define KMSC_SCAN_NS      200
`define KMSC_FRAME_CYC    (`KMSC_FRAME_NS / `KMSC_CLK_NS)
`define KMSC_SCAN_CYC     ((`KMSC_SCAN_NS + `KMSC_CLK_NS - 1) / `KMSC_CLK_NS)

`endif

// *** rtl/kmsc_pkg.sv ***
// Types shared by the key matrix scan controller files.
package kmsc_pkg;

	// Decoded scan modes.
	typedef enum logic [2:0] {
		KMSC_M_ONE,
		KMSC_M_ALL,
		KMSC_M_OFF,
		KMSC_M_EIGHT,
		KMSC_M_FOUR,
		KMSC_M_TWO
	} kmsc_mode_t;

	// Sources of a new setting.
	typedef enum logic [1:0] {
		KMSC_SRC_IMM,
		KMSC_SRC_REG,
		KMSC_SRC_TAB
	} kmsc_src_t;

endpackage

// *** rtl/kmsc_col_decode.sv ***
// Column strobe decoder: turns an 8-bit scan setting into a 16-bit mask.
`timescale 1ns/1ps

module kmsc_col_decode
	import kmsc_pkg::*;
(
	// Setting in.
	input  wire logic [7:0]  setting,
	// Columns out.
	output logic      [15:0] col_mask,
	output kmsc_mode_t       mode
);

	// Mode decode from bits 7, 5 and 4.
	function automatic kmsc_mode_t kmsc_mode_of(input logic [7:0] s);
		case ({s[7], s[5], s[4]})
			3'b000:  kmsc_mode_of = KMSC_M_ONE;
			3'b001:  kmsc_mode_of = KMSC_M_ALL;
			3'b010:  kmsc_mode_of = KMSC_M_OFF;
			3'b110:  kmsc_mode_of = KMSC_M_FOUR;
			3'b111:  kmsc_mode_of = KMSC_M_TWO;
			default: kmsc_mode_of = KMSC_M_EIGHT;
		endcase
	endfunction

	assign mode = kmsc_mode_of(setting);

	// Each column tests whether its index falls in the selected group.
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_col
			always_comb begin
				case (mode)
					KMSC_M_ONE:   col_mask[g] = (setting[3:0] == 4'(g));
					KMSC_M_ALL:   col_mask[g] = 1'b1;
					KMSC_M_OFF:   col_mask[g] = 1'b0;
					KMSC_M_EIGHT: col_mask[g] = (setting[3] == 1'(g / 8));
					KMSC_M_FOUR:  col_mask[g] = (setting[3:2] == 2'(g / 4));
					KMSC_M_TWO:   col_mask[g] = (setting[3:1] == 3'(g / 2));
					default:      col_mask[g] = 1'b0;
				endcase
			end
		end
	endgenerate

endmodule

// *** rtl/kmsc_apb_regs.sv ***
// APB slave holding control, mask and sticky status of the scan controller.
`timescale 1ns/1ps
`include "kmsc_defs.svh"

module kmsc_apb_regs
	import kmsc_pkg::*;
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Block side.
	input  wire logic [7:0]  setting,
	input  wire logic [2:0]  events,
	output logic             op_wr,
	output logic [7:0]       op_data,
	output logic             ctrl_wr,
	output logic [7:0]       ctrl,
	output logic             irq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [31:0] rdata;
		logic        ready;
		logic        err;
		logic [2:0]  status;
		logic [2:0]  mask;
		logic [7:0]  ctrl;
		logic        op_wr;
		logic [7:0]  op_data;
		logic        ctrl_wr;
		logic        irq;
	} kmsc_regs_t;

	kmsc_regs_t cur, next_cur;

	// One wait state: pready rises one cycle into the access phase, and
	// a write takes effect only at the edge where pready is seen high.
	always_comb begin
		logic acc;
		logic wr;
		acc = psel && penable && !cur.ready;
		wr  = psel && penable && pwrite && cur.ready;
		next_cur = cur;
		next_cur.ready = acc;
		next_cur.err = 1'b0;
		next_cur.op_wr = 1'b0;
		next_cur.ctrl_wr = 1'b0;
		// Event sets beat a simultaneous write-one clear.
		next_cur.status = cur.status | events;
		if (acc) begin
			next_cur.rdata = 32'h0;
			case (paddr)
				`KMSC_OFF_SETTING: next_cur.rdata = {24'h0, setting};
				`KMSC_OFF_OPERAND: next_cur.rdata = {24'h0, cur.op_data};
				`KMSC_OFF_STATUS:  next_cur.rdata = {29'h0, cur.status};
				`KMSC_OFF_MASK:    next_cur.rdata = {29'h0, cur.mask};
				`KMSC_OFF_CTRL:    next_cur.rdata = {24'h0, cur.ctrl};
				default:           next_cur.err = 1'b1;
			endcase
		end
		// Writes land on the completing edge; unmapped places are ignored.
		if (wr) begin
			case (paddr)
				`KMSC_OFF_OPERAND: begin
					next_cur.op_data = pwdata[7:0];
					next_cur.op_wr = 1'b1;
				end
				`KMSC_OFF_STATUS:
					next_cur.status = (cur.status & ~pwdata[2:0]) | events;
				`KMSC_OFF_MASK:    next_cur.mask = pwdata[2:0];
				`KMSC_OFF_CTRL: begin
					next_cur.ctrl = pwdata[7:0];
					next_cur.ctrl_wr = 1'b1;
				end
				default: ;
			endcase
		end
		next_cur.irq = |(next_cur.status & next_cur.mask);
	end

	// Register the state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign prdata  = cur.rdata;
	assign pready  = cur.ready;
	assign pslverr = cur.err;
	assign op_wr   = cur.op_wr;
	assign op_data = cur.op_data;
	assign ctrl_wr = cur.ctrl_wr;
	assign ctrl    = cur.ctrl;
	assign irq     = cur.irq;

endmodule

// *** rtl/kmsc_top.sv ***
// Key matrix scan controller: setting load, frame timing, column strobes.
//
// How it works
// - Eight-bit setting drives strobes during scan interval.
// - Periodic clear: wake only after key press.
// - Periodic set: wake every scan cycle end.
// - Mode 000 strobes one column, bits 3-0.
// - Mode 001 strobes all sixteen columns.
// - Mode 010 disables scanning.
// - Mode 10x strobes eight columns, bit 3.
// - Mode 110 strobes four columns, bits 3-2.
// - Mode 111 strobes two columns, bits 3-1.
// - Register form: accumulator high, register low.
// - Table form: eight table bits directly.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "kmsc_defs.svh"

module kmsc_top
	import kmsc_pkg::*;
#(
	parameter int FRAME_CYC = `KMSC_FRAME_CYC,
	parameter int SCAN_CYC  = `KMSC_SCAN_CYC
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB register bus.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core instruction side.
	input  wire logic        set_scan_immediate,
	input  wire logic        set_scan_from_operand,
	input  wire logic        operand_is_table,
	input  wire logic [7:0]  imm_value,
	input  wire logic [3:0]  arith_result_nibble,
	input  wire logic [3:0]  work_reg_nibble,
	input  wire logic [7:0]  table_word,
	input  wire logic        halt_wake_enable_bit,
	// Pins.
	input  wire logic [15:0] lcd_seg_in,
	input  wire logic [3:0]  key_row_in,
	output logic      [15:0] lcd_drive_pins,
	output logic             scan_active,
	// Status to the core.
	output logic             halt_wake_request,
	output logic             scan_cycle_flag,
	output logic             irq
);

	// ****************************************
	// Register interface
	// ****************************************

	// Decoded pieces of the APB side.
	logic       op_wr;
	logic [7:0] op_data;
	logic       ctrl_wr;
	logic [7:0] ctrl;
	logic [2:0] events;
	logic [7:0] setting_q;

	kmsc_apb_regs u_regs (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.setting (setting_q),
		.events  (events),
		.op_wr   (op_wr),
		.op_data (op_data),
		.ctrl_wr (ctrl_wr),
		.ctrl    (ctrl),
		.irq     (irq)
	);

	// ****************************************
	// Column decode
	// ****************************************

	// Column mask of the held setting.
	logic [15:0] col_mask;
	kmsc_mode_t  mode;

	kmsc_col_decode u_dec (
		.setting  (setting_q),
		.col_mask (col_mask),
		.mode     (mode)
	);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]  setting;
		logic [15:0] frame_cnt;
		logic        in_scan;
		logic        key_seen;
		logic [15:0] pins;
		logic        active;
		logic        wake;
		logic        cflag;
		logic [2:0]  ev;
	} kmsc_state_t;

	kmsc_state_t cur, next_cur;

	// Width-trimmed timing limits.
	localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYC - 1);
	localparam logic [15:0] SCAN_LAST  = 16'(SCAN_CYC - 1);

	// Software may clear the flags through bit 0 and bit 1 of control.
	logic clr_wake;
	logic clr_cycle;
	assign clr_wake  = ctrl_wr && ctrl[0];
	assign clr_cycle = ctrl_wr && ctrl[1];

	// Next-state logic: setting load, frame count, strobes and wake flags.
	always_comb begin
		logic end_scan;
		logic pressed;
		logic wake_ev;
		end_scan = 1'b0;
		pressed = 1'b0;
		wake_ev = 1'b0;
		next_cur = cur;
		next_cur.ev = 3'h0;

		// A new load replaces the setting; otherwise it is held.
		if (set_scan_immediate) begin
			next_cur.setting = imm_value;
		end else if (set_scan_from_operand && operand_is_table) begin
			next_cur.setting = table_word;
		end else if (set_scan_from_operand) begin
			next_cur.setting = {arith_result_nibble, work_reg_nibble};
		end else if (op_wr) begin
			next_cur.setting = op_data;
		end

		// Frame counter; the scan interval opens each frame.
		if (cur.frame_cnt == FRAME_LAST) begin
			next_cur.frame_cnt = 16'h0;
		end else begin
			next_cur.frame_cnt = cur.frame_cnt + 16'h1;
		end

		// A disabled setting opens no scan interval at all.
		if (cur.frame_cnt == 16'h0 && mode != KMSC_M_OFF) begin
			next_cur.in_scan = 1'b1;
			next_cur.key_seen = 1'b0;
		end else if (cur.in_scan && cur.frame_cnt == SCAN_LAST) begin
			next_cur.in_scan = 1'b0;
			end_scan = 1'b1;
		end

		// Any active row while strobing counts as a key press.
		if (cur.in_scan && cur.active && |key_row_in) begin
			next_cur.key_seen = 1'b1;
			pressed = 1'b1;
		end

		// Strobe columns in scan; the LCD waveform elsewhere.
		if (next_cur.in_scan) begin
			next_cur.pins = col_mask;
			next_cur.active = 1'b1;
		end else begin
			next_cur.pins = lcd_seg_in;
			next_cur.active = 1'b0;
		end

		// Wake at scan end: periodic or on a key.
		if (end_scan && halt_wake_enable_bit) begin
			if (cur.setting[`KMSC_BIT_PERIODIC]) begin
				wake_ev = 1'b1;
			end else begin
				wake_ev = cur.key_seen || pressed;
			end
		end

		// Set beats clear for both flags.
		if (clr_wake) begin
			next_cur.wake = 1'b0;
		end
		if (clr_cycle) begin
			next_cur.cflag = 1'b0;
		end
		if (wake_ev) begin
			next_cur.wake = 1'b1;
			next_cur.cflag = 1'b1;
		end

		next_cur.ev[`KMSC_ST_WAKE]  = wake_ev;
		next_cur.ev[`KMSC_ST_CYCLE] = end_scan;
		next_cur.ev[`KMSC_ST_KEY]   = pressed;
	end

	// Register the whole state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
			cur.setting <= `KMSC_RST_SETTING;
		end else begin
			cur <= next_cur;
		end
	end

	assign setting_q         = cur.setting;
	assign events            = cur.ev;
	assign lcd_drive_pins    = cur.pins;
	assign scan_active       = cur.active;
	assign halt_wake_request = cur.wake;
	assign scan_cycle_flag   = cur.cflag;

	// ****************************************
	// Assertions
	// ****************************************

	// Every property below is held off while reset is asserted.

	// An immediate load lands on the edge after its pulse.
	a_imm_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		set_scan_immediate |=> setting_q == $past(imm_value))
		else $error("Immediate setting not loaded.");

	// The register form packs the accumulator above the register.
	a_reg_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		!set_scan_immediate && set_scan_from_operand && !operand_is_table
		|=> setting_q == {$past(arith_result_nibble),
			$past(work_reg_nibble)})
		else $error("Register-form setting wrong.");

	// The table form copies the table word bit for bit.
	a_tab_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		!set_scan_immediate && set_scan_from_operand && operand_is_table
		|=> setting_q == $past(table_word))
		else $error("Table-form setting wrong.");

	// Without a load of any kind the setting must not move.
	a_setting_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		!set_scan_immediate && !set_scan_from_operand && !op_wr
		|=> $stable(setting_q))
		else $error("Setting changed without a load.");

	// A disabled setting never opens a scan interval.
	a_off_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode == KMSC_M_OFF && !cur.in_scan |=> !cur.in_scan)
		else $error("Scan opened while disabled.");

	// Outside the interval the pins repeat the LCD waveform.
	a_lcd_pass: assert property (
		@(posedge pclk) disable iff (!presetn)
		!next_cur.in_scan |=> lcd_drive_pins == $past(lcd_seg_in))
		else $error("LCD drive lost outside scan.");

	// Inside the interval the pins carry the decoded strobes.
	a_scan_strobe: assert property (
		@(posedge pclk) disable iff (!presetn)
		next_cur.in_scan |=> scan_active
		&& lcd_drive_pins == $past(col_mask))
		else $error("Strobes missing inside scan.");

	// The last scan cycle hands the pins back to the display.
	a_scan_close: assert property (
		@(posedge pclk) disable iff (!presetn)
		cur.in_scan && cur.frame_cnt == SCAN_LAST
		|=> !scan_active)
		else $error("Scan interval did not close.");

	// A periodic setting wakes the core at every scan end while the enable bit is set.
	a_periodic: assert property (
		@(posedge pclk) disable iff (!presetn)
		cur.in_scan && cur.frame_cnt == SCAN_LAST && halt_wake_enable_bit
		&& setting_q[`KMSC_BIT_PERIODIC]
		|=> halt_wake_request && scan_cycle_flag)
		else $error("Periodic wake missing.");

	// A key-driven wake needs a key seen during the interval.
	a_key_wake: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(halt_wake_request) && !$past(setting_q[`KMSC_BIT_PERIODIC])
		|-> $past(cur.key_seen) || $past(|key_row_in))
		else $error("Wake raised without a key.");

	// No wake at all unless the enable bit was set.
	a_wake_gated: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(halt_wake_request) |-> $past(halt_wake_enable_bit))
		else $error("Wake raised while not enabled.");

	// A wake only follows the last cycle of a scan interval.
	a_wake_at_end: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(halt_wake_request)
		|-> $past(cur.in_scan && cur.frame_cnt == SCAN_LAST))
		else $error("Wake raised away from scan end.");

	// The scan cycle flag is set together with the wake.
	a_flag_follow: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(halt_wake_request) |-> scan_cycle_flag)
		else $error("Cycle flag missing with wake.");

	// Single-column mode strobes exactly the addressed column.
	a_one_col: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode == KMSC_M_ONE |-> $onehot(col_mask)
		&& col_mask[setting_q[3:0]])
		else $error("Single-column mode not one-hot.");

	// All-column mode strobes every column.
	a_all_col: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode == KMSC_M_ALL |-> col_mask == 16'hFFFF)
		else $error("All-column mode incomplete.");

	// Eight-column mode strobes one aligned half, both ends included.
	a_group_col: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode == KMSC_M_EIGHT |-> $countones(col_mask) == 8
		&& col_mask[{setting_q[3], 3'h0}]
		&& col_mask[{setting_q[3], 3'h7}])
		else $error("Eight-column group wrong.");

	// Four-column mode strobes one aligned quarter, both ends included.
	a_four_col: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode == KMSC_M_FOUR |-> $countones(col_mask) == 4
		&& col_mask[{setting_q[3:2], 2'h0}]
		&& col_mask[{setting_q[3:2], 2'h3}])
		else $error("Four-column group wrong.");

	// Two-column mode strobes one aligned pair.
	a_two_col: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode == KMSC_M_TWO |-> $countones(col_mask) == 2
		&& col_mask[{setting_q[3:1], 1'h0}]
		&& col_mask[{setting_q[3:1], 1'h1}])
		else $error("Two-column group wrong.");

endmodule

// *** verif/kmsc_key_matrix.sv ***
// Model of the key switch matrix that answers column strobes on the rows.
`timescale 1ns/1ps

module kmsc_key_matrix (
	// Clock.
	input  wire logic        pclk,
	// Strobes from the block.
	input  wire logic        scan_active,
	input  wire logic [15:0] lcd_drive_pins,
	// Key held by the bench.
	input  wire logic        press,
	input  wire logic [3:0]  press_col,
	input  wire logic        slow,
	// Rows back to the block.
	output logic      [3:0]  key_row_in
);
	logic [3:0] row_now;  // Rows as the contact closes.
	logic [3:0] row_late; // Rows seen one clock late.

	// A closed key ties its column to row zero; idle rows are pulled low.
	always_comb begin
		row_now = 4'h0;
		if (press && scan_active && lcd_drive_pins[press_col]) begin
			row_now = 4'h1;
		end
	end

	// A slow contact answers a clock late, so timing slack is exercised.
	always_ff @(posedge pclk) begin
		row_late <= row_now;
	end

	assign key_row_in = slow ? row_late : row_now;
endmodule

// *** verif/tb.sv ***
// Self-checking bench of the key matrix scan controller.
`timescale 1ns/1ps
`include "kmsc_defs.svh"

module tb;
	localparam int          FR  = 20;       // Short frame for simulation.
	localparam int          SC  = 5;        // Short scan interval.
	localparam logic [15:0] SEG = 16'hA5C3; // Idle LCD waveform.
	localparam logic [15:0] SEG_ALT = 16'h5A3C; // Second LCD waveform.
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        set_scan_immediate, set_scan_from_operand;
	logic        operand_is_table, halt_wake_enable_bit, er, press, slow;
	logic [7:0]  imm_value, table_word;
	logic [3:0]  arith_result_nibble, work_reg_nibble, key_row_in, pcol;
	logic        scan_active, halt_wake_request, scan_cycle_flag, irq;
	logic [15:0] lcd_seg_in, lcd_drive_pins;
	int          bad_count, cmp_count, wd;
	logic [7:0]  mtab [0:8] = '{8'h00, 8'h0F, 8'h1A, 8'h83, 8'h98,
		8'hA0, 8'hAF, 8'hB1, 8'hBE}; // Every scanning mode and its edges.

	kmsc_top #(.FRAME_CYC(FR), .SCAN_CYC(SC)) kmsc_top_i (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .set_scan_immediate,
		.set_scan_from_operand, .operand_is_table, .imm_value,
		.arith_result_nibble, .work_reg_nibble, .table_word,
		.halt_wake_enable_bit, .lcd_seg_in, .key_row_in,
		.lcd_drive_pins, .scan_active, .halt_wake_request,
		.scan_cycle_flag, .irq);
	kmsc_key_matrix kmsc_key_matrix_i (.pclk, .scan_active,
		.lcd_drive_pins, .press, .press_col(pcol), .slow, .key_row_in);

	// ********
	// Clock, watchdog and reporting
	// ********
	// The clock toggles every half period of 2.5 ns.
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// A hung wait is cut short well past the expected run length.
	always @(posedge pclk) begin
		wd <= wd + 1;
		if (wd == 20000) begin
			bad_count++;
			final_report();
		end
	end

	// Prints the verdict and ends the run.
	task final_report;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Compares one value and counts it.
	task chk(input logic [31:0] seen, input logic [31:0] exp, string m);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	// Expected strobes of a setting, worked out by shifting a group mask.
	function automatic logic [15:0] exp_mask(logic [7:0] s);
		case ({s[7], s[5], s[4]})
			3'b000: return 16'h0001 << s[3:0];
			3'b001: return 16'hFFFF;
			3'b100, 3'b101: return 16'h00FF << {s[3], 3'b000};
			3'b110: return 16'h000F << {s[3:2], 2'b00};
			3'b111: return 16'h0003 << {s[3:1], 1'b0};
			default: return 16'h0000;
		endcase
	endfunction

	// ********
	// Drivers
	// ********
	// One APB transfer; the request holds until pready is seen high.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Loads an immediate setting with a one-cycle pulse.
	task ld(input logic [7:0] v);
		@(posedge pclk);
		set_scan_immediate <= 1'b1;
		imm_value <= v;
		@(posedge pclk);
		set_scan_immediate <= 1'b0;
	endtask

	// Waits for the start of the next scan interval. One edge passes first,
	// so an interval opened with the setting just replaced is skipped.
	task scan_on;
		int n;
		n = 0;
		@(posedge pclk);
		while (scan_active === 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		while (scan_active !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk(n < 200, 1, "scan never started");
	endtask

	// Waits until the scan interval is over and its flags have landed.
	task scan_off;
		int n;
		n = 0;
		while (scan_active === 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		repeat (3) @(posedge pclk);
	endtask

	// Disables scanning and clears every flag and status bit.
	task clr;
		ld(`KMSC_RST_SETTING);
		repeat (FR) @(posedge pclk);
		apb(1'b1, `KMSC_OFF_CTRL, 32'h3);
		apb(1'b1, `KMSC_OFF_STATUS, 32'h7);
		@(posedge pclk);
		chk({halt_wake_request, scan_cycle_flag}, 0, "flags set");
	endtask

	// ********
	// Scenarios
	// ********
	// Reset value, read-only setting, unmapped place, operand write.
	task t_regs;
		apb(1'b0, `KMSC_OFF_SETTING, 0);
		chk(rd, `KMSC_RST_SETTING, "reset setting");
		apb(1'b1, `KMSC_OFF_SETTING, 32'h55);
		apb(1'b0, `KMSC_OFF_SETTING, 0);
		chk(rd, `KMSC_RST_SETTING, "setting written");
		apb(1'b0, 12'hFFC, 0);
		chk(er, 1'b1, "unmapped error");
		chk(rd, 32'h0, "unmapped read");
		apb(1'b1, `KMSC_OFF_OPERAND, 32'h0F);
		apb(1'b0, `KMSC_OFF_SETTING, 0);
		chk(rd, 32'h0F, "operand load");
	endtask

	// Every scanning mode, held over two scans, then LCD drive between scans.
	task t_modes;
		for (int i = 0; i < 9; i++) begin
			ld(mtab[i]);
			scan_on();
			chk(lcd_drive_pins, exp_mask(mtab[i]), "strobe");
			scan_on();
			chk(lcd_drive_pins, exp_mask(mtab[i]), "held");
			scan_off();
			chk(lcd_drive_pins, SEG, "lcd drive");
		end
	endtask

	// Disabled mode never opens a scan with bits 3 to 0 all set.
	task t_off;
		int hits;
		hits = 0;
		ld(8'h2F);
		repeat (2 * FR) begin
			@(posedge pclk);
			hits += (scan_active !== 1'b0);
		end
		chk(hits, 0, "scan while off");
		chk(lcd_drive_pins, SEG, "lcd drive off");
		lcd_seg_in <= SEG_ALT;
		repeat (2) @(posedge pclk);
		chk(lcd_drive_pins, SEG_ALT, "lcd drive follows");
		lcd_seg_in <= SEG;
	endtask

	// Register form, table form, and immediate priority.
	task t_src;
		@(posedge pclk);
		{arith_result_nibble, work_reg_nibble} <= 8'h88;
		operand_is_table <= 1'b0;
		set_scan_from_operand <= 1'b1;
		@(posedge pclk);
		set_scan_from_operand <= 1'b0;
		apb(1'b0, `KMSC_OFF_SETTING, 0);
		chk(rd, 32'h88, "register form");
		scan_on();
		chk(lcd_drive_pins, 16'hFF00, "register strobe");
		table_word <= 8'hE6;
		operand_is_table <= 1'b1;
		set_scan_from_operand <= 1'b1;
		@(posedge pclk);
		set_scan_from_operand <= 1'b0;
		scan_on();
		chk(lcd_drive_pins, 16'h00F0, "table strobe");
		table_word <= 8'h22;
		set_scan_from_operand <= 1'b1;
		ld(8'h11);
		set_scan_from_operand <= 1'b0;
		apb(1'b0, `KMSC_OFF_SETTING, 0);
		chk(rd, 32'h11, "load priority");
	endtask

	// Wake gating, periodic wake, and wake on a strobed key only.
	task t_wake;
		clr();
		ld(8'h50);
		scan_on();
		scan_off();
		chk(halt_wake_request, 0, "wake while disabled");
		halt_wake_enable_bit <= 1'b1;
		scan_on();
		scan_off();
		chk({halt_wake_request, scan_cycle_flag}, 3, "periodic");
		clr();
		press <= 1'b1;
		pcol <= 4'h4;
		ld(8'h03);
		scan_on();
		scan_off();
		chk(halt_wake_request, 0, "unstrobed key");
		pcol <= 4'h3;
		slow <= 1'b1;
		scan_on();
		scan_off();
		chk({halt_wake_request, scan_cycle_flag}, 3, "key wake");
		apb(1'b0, `KMSC_OFF_STATUS, 0);
		chk(rd[2], 1'b1, "key status");
		press <= 1'b0;
		slow <= 1'b0;
	endtask

	// Interrupt raised, masked, unmasked and cleared.
	task t_irq;
		clr();
		apb(1'b1, `KMSC_OFF_MASK, 32'h2);
		ld(8'h10);
		scan_on();
		scan_off();
		chk(irq, 1'b1, "irq raised");
		apb(1'b1, `KMSC_OFF_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0, "irq masked");
		ld(`KMSC_RST_SETTING);
		repeat (FR) @(posedge pclk);
		apb(1'b1, `KMSC_OFF_MASK, 32'h2);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1, "irq unmasked");
		apb(1'b1, `KMSC_OFF_STATUS, 32'h2);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0, "irq cleared");
		apb(1'b0, `KMSC_OFF_STATUS, 0);
		chk(rd[1], 1'b0, "status cleared");
	endtask

	// Main sequence: reset for three cycles, then every scenario.
	initial begin
		{psel, penable, pwrite, set_scan_immediate, press, slow} = '0;
		{set_scan_from_operand, operand_is_table} = '0;
		halt_wake_enable_bit = 1'b0;
		{paddr, pwdata, imm_value, table_word, pcol} = '0;
		{arith_result_nibble, work_reg_nibble} = '0;
		lcd_seg_in = SEG;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_modes();
		t_off();
		t_src();
		t_wake();
		t_irq();
		final_report();
	end
endmodule
